//--- verilog/asr_defines.svh
// Timing and geometry constants for the async SRAM host controller
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ==========================================================
// Geometry
`define ASR_ADDR_W 19
`define ASR_DATA_W 8

// ==========================================================
// Times in their own units
`define ASR_CLK_PERIOD_NS 10
`define ASR_POWER_ON_WAIT_US 100
`define ASR_ADDR_ACCESS_NS 10
`define ASR_SELECT_ACCESS_NS 10
`define ASR_OUTEN_ACCESS_NS 5
`define ASR_ADDR_CHANGE_HOLD_NS 3
`define ASR_DESELECT_PD_NS 10
`define ASR_WRITE_DATA_SETUP_NS 6
`define ASR_WRITE_DATA_HOLD_NS 0
`define ASR_STROBE_BUS_RELEASE_NS 5

// ==========================================================
// Cycle counts: access times round up, at least one cycle; the power-on count truncates
`define ASR_CEIL_CYC(ns) \
   ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
`define ASR_POWER_ON_CYC \
   ((`ASR_POWER_ON_WAIT_US * 1000) / `ASR_CLK_PERIOD_NS)
`define ASR_READ_CYC `ASR_CEIL_CYC(`ASR_SELECT_ACCESS_NS)
`define ASR_WRITE_CYC \
   `ASR_CEIL_CYC(`ASR_STROBE_BUS_RELEASE_NS + `ASR_WRITE_DATA_SETUP_NS)
`define ASR_DESELECT_CYC `ASR_CEIL_CYC(`ASR_DESELECT_PD_NS)

`endif

//--- verilog/asr_pkg.sv
// Types shared by the async SRAM host controller
package asr_pkg;
   typedef enum logic [2:0] {
      ASR_ST_POWER,
      ASR_ST_IDLE,
      ASR_ST_READ,
      ASR_ST_WRITE,
      ASR_ST_RECOVER
   } asr_state_t;
endpackage

//--- verilog/asr_cnt_if.sv
// Carrier between the controller and its phase timer
`timescale 1ns/1ps
interface asr_cnt_if #(parameter int CW = 14);
   logic load;
   logic [CW-1:0] value;
   logic done;
   modport ctl (output load, output value, input done);
   modport tmr (input load, input value, output done);
endinterface

//--- verilog/asr_timer.sv
// Down counter that times each bus phase of the controller
`timescale 1ns/1ps
module asr_timer #(
   parameter int CW = 14
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control from the sequencer
   asr_cnt_if.tmr cnt
);
   logic [CW-1:0] cnt_reg;
   logic done_reg;
   wire cnt_zero = (cnt_reg == '0);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else if (cnt.load) begin
         cnt_reg <= cnt.value;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_zero ? cnt_reg : cnt_reg - 1'b1;
         done_reg <= (cnt_reg == {{(CW-1){1'b0}}, 1'b1});
      end
   end
   assign cnt.done = done_reg;
endmodule

//--- verilog/asr_host.sv
// Host-side controller for a 512K x 8 asynchronous static memory
`timescale 1ns/1ps
`include "asr_defines.svh"
module asr_host #(
   parameter int ADDR_W = `ASR_ADDR_W,
   parameter int DATA_W = `ASR_DATA_W,
   parameter int POWER_ON_CYC = `ASR_POWER_ON_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // User request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   // User answer
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   // Memory pins
   output logic [ADDR_W-1:0] addr_lines,
   output logic select_n,
   output logic outen_n,
   output logic strobe_n,
   input wire logic [DATA_W-1:0] data_lines_i,
   output logic [DATA_W-1:0] data_lines_o,
   output logic data_lines_oe
);
   import asr_pkg::*;

   localparam int CW = 14;
   localparam int READ_CYC = `ASR_READ_CYC;
   localparam int WRITE_CYC = `ASR_WRITE_CYC;
   localparam int DESEL_CYC = `ASR_DESELECT_CYC;

   // ==========================================================
   // Parameter checks
   if (ADDR_W != 19 || DATA_W != 8) begin : g_bad_geometry
      $error("memory geometry must be 19 x 8");
   end
   if (POWER_ON_CYC < 1 || POWER_ON_CYC >= (1 << CW)) begin : g_bad_power
      $error("power-on count out of counter range");
   end

   // ==========================================================
   // State
   asr_state_t state_reg, state_next;
   asr_cnt_if #(.CW(CW)) cnt ();

   asr_timer #(.CW(CW)) u_timer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cnt(cnt)
   );

   logic phase_started;
   wire take_req = (state_reg == ASR_ST_IDLE) && req_valid;
   wire phase_done = cnt.done;
   wire enter_recover = (state_reg == ASR_ST_READ ||
                         state_reg == ASR_ST_WRITE) && phase_done;
   wire in_read = (state_reg == ASR_ST_READ);
   wire power_load = (state_reg == ASR_ST_POWER) && !phase_started;

   always_ff @(posedge core_clk) begin
      if (sys_rst)
         phase_started <= 1'b0;
      else
         phase_started <= 1'b1;
   end

   // ==========================================================
   // Phase timer loads
   assign cnt.load = power_load || take_req || enter_recover;
   assign cnt.value = power_load ? CW'(POWER_ON_CYC) :
                      (take_req && req_write) ? CW'(WRITE_CYC) :
                      take_req ? CW'(READ_CYC) :
                      CW'(DESEL_CYC);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ASR_ST_POWER: begin
            if (phase_started && phase_done)
               state_next = ASR_ST_IDLE;
         end
         ASR_ST_IDLE: begin
            if (req_valid)
               state_next = req_write ? ASR_ST_WRITE : ASR_ST_READ;
         end
         ASR_ST_READ: begin
            if (phase_done)
               state_next = ASR_ST_RECOVER;
         end
         ASR_ST_WRITE: begin
            if (phase_done)
               state_next = ASR_ST_RECOVER;
         end
         ASR_ST_RECOVER: begin
            if (phase_done)
               state_next = ASR_ST_IDLE;
         end
         default: state_next = ASR_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst)
         state_reg <= ASR_ST_POWER;
      else
         state_reg <= state_next;
   end

   // ==========================================================
   // Pin drive, all from flip-flops
   // Select and strobe rise together, so the data is held one more
   // cycle past the end: hold of zero is met with margin.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_lines <= '0;
         select_n <= 1'b1;
         outen_n <= 1'b1;
         strobe_n <= 1'b1;
         data_lines_o <= '0;
         data_lines_oe <= 1'b0;
      end else if (take_req) begin
         addr_lines <= req_addr;
         select_n <= 1'b0;
         strobe_n <= !req_write;
         outen_n <= req_write;
         data_lines_o <= req_wdata;
         data_lines_oe <= req_write;
      end else if (enter_recover) begin
         select_n <= 1'b1;
         strobe_n <= 1'b1;
         outen_n <= 1'b1;
      end else if (state_reg == ASR_ST_RECOVER) begin
         data_lines_oe <= 1'b0;
      end
   end

   // ==========================================================
   // Request and answer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         req_ready <= (state_next == ASR_ST_IDLE);
         rsp_valid <= enter_recover;
         if (in_read && phase_done)
            rsp_rdata <= data_lines_i;
      end
   end

   // ==========================================================
   // Checks
   // Counts from reset on its own, so the wait check does not lean on
   // the phase timer that it guards
   logic [CW-1:0] since_rst_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         since_rst_reg <= '0;
      else if (since_rst_reg != CW'(POWER_ON_CYC))
         since_rst_reg <= since_rst_reg + 1'b1;
   end

   write_overlap_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $fell(strobe_n) |-> !select_n [*2])
      else $error("strobe low without select for the write time");
   no_clash_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      data_lines_oe |-> outen_n)
      else $error("data driven while memory outputs enabled");
   write_end_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $rose(strobe_n) |-> $rose(select_n) && data_lines_oe)
      else $error("write ended without data held");
   power_wait_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $fell(select_n) |-> since_rst_reg == CW'(POWER_ON_CYC))
      else $error("access before power-on wait");
   read_shape_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $fell(outen_n) |-> strobe_n && !select_n [*2])
      else $error("read controls malformed");
   write_len_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $fell(strobe_n) |=> !strobe_n [*2] ##1 $rose(strobe_n))
      else $error("write length wrong");
   deselect_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $rose(select_n) |=> select_n && !req_ready)
      else $error("reselected inside standby time");
   read_answer_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $fell(outen_n) |-> ##2 rsp_valid)
      else $error("read answer late");
   idle_release_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      req_ready |-> select_n && strobe_n && !data_lines_oe)
      else $error("bus not released while idle");
   write_outen_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      !strobe_n |-> outen_n)
      else $error("memory outputs enabled during a write");
endmodule

//--- dv/asr_sram_model.sv
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/1ps
module asr_sram_model #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 8
) (
   // Memory pins
   input wire logic [ADDR_W-1:0] addr_lines,
   input wire logic select_n,
   input wire logic outen_n,
   input wire logic strobe_n,
   input wire logic [DATA_W-1:0] data_lines,
   // Device side of the data lines
   output logic [DATA_W-1:0] dev_d,
   output logic dev_oe
);
   logic [DATA_W-1:0] mem [int];
   logic wr_act;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   // ==========================================================
   // Controls are levels, no clock
   assign wr_act = !select_n && !strobe_n;
   // Drives only in a read; releases at once, so never late
   assign dev_oe = !select_n
                   && !outen_n
                   && strobe_n;
   // Re-read on every control change, so a read of a byte just
   // written at the same address sees the stored value
   always @(addr_lines or select_n or outen_n or strobe_n) begin
      dev_d = '0;
      if (mem.exists(int'(addr_lines)))
         dev_d = mem[int'(addr_lines)];
   end
   always @* begin
      if (wr_act) begin
         wr_addr = addr_lines;
         wr_data = data_lines;
      end
   end
   // Stored when the first of select or strobe rises
   always @(negedge wr_act) begin
      if (!$isunknown(wr_addr))
         mem[int'(wr_addr)] = wr_data;
   end
endmodule

//--- dv/tb.sv
// Self-checking bench of the async SRAM host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
   localparam int PWR = 20;
   localparam int LIMIT = 2000;
   logic core_clk, sys_rst, req_valid, req_write, req_ready, rsp_valid;
   logic [18:0] req_addr, addr_lines, a, cur_a;
   logic [7:0] req_wdata, rsp_rdata, data_lines_o, dev_d, bus, cur_d, d;
   logic [7:0] last_bus = 8'h00;
   logic select_n, outen_n, strobe_n, data_lines_oe, dev_oe;
   logic [7:0] ref_mem [int];
   int errors = 0, n_checks = 0, ov = 0, cyc = 0, seed, n;
   bit ready_seen = 0;
   // ==========================================================
   // Wire with no pull: an undriven bus shows the inverse
   assign bus = data_lines_oe ? data_lines_o : dev_oe ? dev_d : ~last_bus;
   always @(posedge core_clk) if (data_lines_oe || dev_oe) last_bus <= bus;
   asr_host #(.POWER_ON_CYC(PWR)) u_dut (.core_clk(core_clk),
      .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .addr_lines(addr_lines), .select_n(select_n), .outen_n(outen_n),
      .strobe_n(strobe_n), .data_lines_i(bus),
      .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));
   asr_sram_model u_mem (.addr_lines(addr_lines), .select_n(select_n),
      .outen_n(outen_n), .strobe_n(strobe_n), .data_lines(bus),
      .dev_d(dev_d), .dev_oe(dev_oe));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic access(input logic w, input logic [18:0] ad,
                         input logic [7:0] wd);
      int k;
      logic [7:0] ed;
      k = 0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= ad;
      req_wdata <= wd;
      do begin @(posedge core_clk); k++; end
      while (req_ready !== 1'b1 && k < 50);
      req_valid <= 1'b0;
      cur_d = wd;
      cur_a = ad;
      if (w) ref_mem[int'(ad)] = wd;
      k = 0;
      do begin @(posedge core_clk); k++; end
      while (rsp_valid !== 1'b1 && k < 20);
      `CHK("rsp_valid", 1'b1, rsp_valid)
      if (!w) begin
         ed = ref_mem.exists(int'(ad)) ? ref_mem[int'(ad)] : 8'h00;
         `CHK("rsp_rdata", ed, rsp_rdata)
      end
   endtask
   // ==========================================================
   // Pin monitor
   always @(posedge core_clk) begin
      cyc++;
      if (!sys_rst) begin
         if (select_n === 1'b0)
            `CHK("address", cur_a, addr_lines)
         if (select_n === 1'b0 && strobe_n === 1'b0) begin
            ov <= ov + 1;
            `CHK("write data", cur_d, data_lines_o)
            `CHK("write drive", 1'b1, data_lines_oe)
         end else if (ov != 0) begin
            `CHK("write length", 1'b1, ov >= 2)
            `CHK("joint rise", select_n, strobe_n)
            ov <= 0;
         end
         if (select_n === 1'b0 && outen_n === 1'b0)
            `CHK("read strobe", 1'b1, strobe_n)
         `CHK("contention", 1'b0, dev_oe && data_lines_oe)
         if (!ready_seen)
            `CHK("idle select", 1'b1, select_n)
      end
      if (cyc == LIMIT) begin
         errors++;
         conclude();
      end
   end
   initial begin
      seed = 59;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 19'h00000;
      req_wdata = 8'h00;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      `CHK("power wait", 1'b1, n >= PWR)
      `CHK("power ready", 1'b1, req_ready)
      ready_seen = 1;
      $display("test power done");
      access(1'b1, 19'h00000, 8'hA5);
      access(1'b1, 19'h7FFFF, 8'h5A);
      access(1'b0, 19'h00000, 8'h00);
      access(1'b0, 19'h7FFFF, 8'h00);
      $display("test boundary done");
      for (int i = 0; i < 80; i++) begin
         a = {15'h2B3C, 4'($random(seed))};
         d = 8'($random(seed));
         access(1'($random(seed)), a, d);
      end
      $display("test random done");
      conclude();
   end
endmodule
